// >>> src/mism_top.sv
/*
 * interrupt status and mask block of an ethernet controller, AHB-Lite slave.
 * assumes event inputs are one-cycle pulses synchronous to clk, except
 * rx_engine_running, which is a level from the receive engine.
 */
// Contract
// - a written-back transmit descriptor carrying an interrupt request sets status bit 7.
// - the last transmit descriptor of a good transmission written back sets status bit 6.
// - a receive data fifo overrun sets status bit 5.
// - the receive engine going from running to idle sets status bit 4.
// - reaching the receive drain threshold sets status bit 3, at most once per packet.
// - the last receive descriptor of a failed reception written back sets status bit 2.
// - any written-back receive descriptor carrying an interrupt request sets status bit 1.
// - the last receive descriptor of a good packet written back sets status bit 0.
// - a one in the mask register at 0014h enables the interrupt of the same status bit.
// - hard and soft reset both clear the mask register to 00000000h.
// - status bits latch to one on their condition whatever the mask says.
// - a status bit with a zero mask bit never drives the interrupt but stays readable.
// - mask bits exist at 25..20 and 16..0 only; the others read as zero.
// - a global enable bit gates the interrupt output without touching status or mask.
`timescale 1ns/1ps
module mism_top
   import mism_pkg::*;
(
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   // ahb-lite slave
   input  wire logic                   hsel,
   input  wire logic [MISM_ADDR_W-1:0] haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [MISM_DATA_W-1:0] hwdata,
   input  wire logic                   hready,
   output      logic [MISM_DATA_W-1:0] hrdata,
   output      logic                   hreadyout,
   output      logic                   hresp,
   // transmit engine events
   input  wire logic                   tx_desc_writeback,
   input  wire logic                   tx_desc_last,
   input  wire logic                   tx_status_good,
   input  wire logic                   tx_descriptor_irq_request,
   // receive engine events
   input  wire logic                   rx_desc_writeback,
   input  wire logic                   rx_desc_last,
   input  wire logic                   rx_status_good,
   input  wire logic                   rx_descriptor_irq_request,
   input  wire logic                   rx_fifo_overrun,
   input  wire logic                   rx_engine_running,
   input  wire logic                   rx_packet_start,
   input  wire logic                   rx_early_threshold,
   // other sources for bits 31..8
   input  wire logic [MISM_DATA_W-1:0] aux_event,
   // host interrupt and soft reset pulse to neighbours
   output      logic                   irq,
   output      logic                   soft_reset_pulse
);
   import mism_pkg::*;

   // reset release through two flip-flops
   logic rst_meta_q;
   logic rst_sync_b;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_q <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_b <= rst_meta_q;
      end
   end

   // bus front end state
   mism_bus_state_type     state_q;
   mism_bus_state_type     state_d;
   logic [MISM_ADDR_W-1:0] addr_q;
   logic [MISM_DATA_W-1:0] hrdata_q;
   logic                   hreadyout_q;
   logic                   hresp_q;

   // register state
   logic [MISM_DATA_W-1:0] mask_q;
   logic [MISM_DATA_W-1:0] mask_d;
   logic                   enable_q;
   logic                   enable_d;
   logic                   irq_q;
   logic                   soft_q;
   logic                   rx_running_q;
   logic                   early_armed_q;
   logic                   early_armed_d;

   // status latch
   mism_evt_if #(.WIDTH(MISM_DATA_W)) evt ();

   mism_event_latch #(
      .WIDTH    (MISM_DATA_W),
      .IMPL     (MISM_IMPL_BITS),
      .HARD_VAL (MISM_STATUS_HARD),
      .SOFT_VAL (MISM_STATUS_SOFT)
   ) u_latch (
      .clk        (clk),
      .rst_sync_b (rst_sync_b),
      .evt        (evt)
   );

   // address phase accept
   wire accept     = hsel && htrans == MISM_HTRANS_NONSEQ && hready;
   wire in_read    = state_q == MISM_BUS_READ;
   wire in_write   = state_q == MISM_BUS_WRITE;

   // data phase decode on the latched address
   wire hit_ctl    = addr_q == MISM_OFS_CONTROL;
   wire hit_status = addr_q == MISM_OFS_STATUS;
   wire hit_mask   = addr_q == MISM_OFS_MASK;
   wire hit_enable = addr_q == MISM_OFS_ENABLE;

   wire wr_ctl     = in_write && hit_ctl;
   wire wr_mask    = in_write && hit_mask;
   wire wr_enable  = in_write && hit_enable;
   wire rd_status  = in_read && hit_status;

   // self-clearing control actions
   wire soft_go    = wr_ctl && hwdata[MISM_CTL_SOFT_RST];
   wire swi_go     = wr_ctl && hwdata[MISM_CTL_SW_IRQ];

   always_comb begin
      state_d = MISM_BUS_IDLE;
      unique case (state_q)
         MISM_BUS_READ: begin
            state_d = MISM_BUS_IDLE;
         end
         MISM_BUS_IDLE, MISM_BUS_WRITE: begin
            if (accept && hwrite) begin
               state_d = MISM_BUS_WRITE;
            end else if (accept) begin
               state_d = MISM_BUS_READ;
            end
         end
         default: begin
            state_d = MISM_BUS_IDLE;
         end
      endcase
   end

   // read data selection; unmapped addresses read zero
   wire [MISM_DATA_W-1:0] enable_word = {{(MISM_DATA_W-1){1'b0}}, enable_q};
   wire [MISM_DATA_W-1:0] rd_word =
      hit_status ? evt.status_vec :
      hit_mask   ? mask_q :
      hit_enable ? enable_word :
      MISM_ZERO_WORD;

   // mask register: software write, cleared by soft reset
   assign mask_d   = soft_q  ? MISM_MASK_RESET :
                     wr_mask ? (hwdata & MISM_IMPL_BITS) : mask_q;
   assign enable_d = soft_q    ? 1'b0 :
                     wr_enable ? hwdata[MISM_ENA_BIT] : enable_q;

   // early threshold re-arms at each packet start, fires once
   wire early_fire = rx_early_threshold && early_armed_q;
   assign early_armed_d = soft_q          ? 1'b1 :
                          rx_packet_start ? 1'b1 :
                          early_fire      ? 1'b0 : early_armed_q;

   // event sets
   logic [MISM_DATA_W-1:0] set_low;
   logic [MISM_DATA_W-1:0] set_vec;
   wire  rx_last_wb  = rx_desc_writeback && rx_desc_last;
   wire  tx_last_wb  = tx_desc_writeback && tx_desc_last;
   wire  high_any    = |set_low[MISM_BIT_HIGH_HI:MISM_BIT_HIGH_LO];

   always_comb begin
      set_low = aux_event & MISM_IMPL_BITS;
      set_low[MISM_BIT_TX_DESC]  = tx_desc_writeback && tx_descriptor_irq_request;
      set_low[MISM_BIT_TX_GOOD]  = tx_last_wb && tx_status_good;
      set_low[MISM_BIT_RX_ORUN]  = rx_fifo_overrun;
      set_low[MISM_BIT_RX_IDLE]  = rx_running_q && !rx_engine_running;
      set_low[MISM_BIT_RX_EARLY] = early_fire;
      set_low[MISM_BIT_RX_FAIL]  = rx_last_wb && !rx_status_good;
      set_low[MISM_BIT_RX_DESC]  = rx_desc_writeback && rx_descriptor_irq_request;
      set_low[MISM_BIT_RX_GOOD]  = rx_last_wb && rx_status_good;
      set_low[MISM_BIT_SW_IRQ]   = aux_event[MISM_BIT_SW_IRQ] || swi_go;
   end

   // summary bit follows any upper event
   always_comb begin
      set_vec = set_low;
      set_vec[MISM_BIT_SUMMARY] = set_low[MISM_BIT_SUMMARY] || high_any;
   end

   assign evt.set_vec   = set_vec;
   assign evt.clear_vec = rd_status ? evt.status_vec : MISM_ZERO_WORD;
   assign evt.soft_load = soft_q;

   // interrupt: masked status, gated by the global enable
   wire pending = |(evt.status_vec & mask_q);
   wire irq_d   = pending && enable_q;

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state_q <= MISM_BUS_IDLE;
         hreadyout_q <= 1'b1;
         hresp_q <= MISM_HRESP_OKAY;
      end else begin
         state_q <= state_d;
         hreadyout_q <= state_d != MISM_BUS_READ;
         hresp_q <= MISM_HRESP_OKAY;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         addr_q <= MISM_OFS_CONTROL;
      end else if (accept) begin
         addr_q <= haddr;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         hrdata_q <= MISM_ZERO_WORD;
      end else if (in_read) begin
         hrdata_q <= rd_word;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         mask_q <= MISM_MASK_RESET;
         enable_q <= 1'b0;
      end else begin
         mask_q <= mask_d;
         enable_q <= enable_d;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         soft_q <= 1'b0;
         rx_running_q <= 1'b0;
         early_armed_q <= 1'b1;
         irq_q <= 1'b0;
      end else begin
         soft_q <= soft_go;
         rx_running_q <= rx_engine_running;
         early_armed_q <= early_armed_d;
         irq_q <= irq_d;
      end
   end

   assign hrdata           = hrdata_q;
   assign hreadyout        = hreadyout_q;
   assign hresp            = hresp_q;
   assign irq              = irq_q;
   assign soft_reset_pulse = soft_q;

endmodule : mism_top

// >>> src/mism_pkg.sv
/*
 * constants, register map and types of the interrupt status and mask block.
 * assumes a 32-bit AHB-Lite register bus and one 100 MHz clock.
 */
package mism_pkg;

   localparam int unsigned MISM_DATA_W = 32;
   localparam int unsigned MISM_ADDR_W = 8;

   // byte addresses of the registers
   localparam logic [MISM_ADDR_W-1:0] MISM_OFS_CONTROL = 8'h04;
   localparam logic [MISM_ADDR_W-1:0] MISM_OFS_STATUS  = 8'h10;
   localparam logic [MISM_ADDR_W-1:0] MISM_OFS_MASK    = 8'h14;
   localparam logic [MISM_ADDR_W-1:0] MISM_OFS_ENABLE  = 8'h18;

   // implemented bits: 25..20 and 16..0
   localparam logic [31:0] MISM_IMPL_BITS     = 32'h03F1FFFF;
   localparam logic [31:0] MISM_MASK_RESET    = 32'h00000000;
   localparam logic [31:0] MISM_STATUS_HARD   = 32'h00000000;
   localparam logic [31:0] MISM_STATUS_SOFT   = 32'h03008000;
   localparam logic [31:0] MISM_ZERO_WORD     = 32'h00000000;

   // status bit positions
   localparam int unsigned MISM_BIT_RX_GOOD   = 0;
   localparam int unsigned MISM_BIT_RX_DESC   = 1;
   localparam int unsigned MISM_BIT_RX_FAIL   = 2;
   localparam int unsigned MISM_BIT_RX_EARLY  = 3;
   localparam int unsigned MISM_BIT_RX_IDLE   = 4;
   localparam int unsigned MISM_BIT_RX_ORUN   = 5;
   localparam int unsigned MISM_BIT_TX_GOOD   = 6;
   localparam int unsigned MISM_BIT_TX_DESC   = 7;
   localparam int unsigned MISM_BIT_SW_IRQ    = 12;
   localparam int unsigned MISM_BIT_SUMMARY   = 15;
   localparam int unsigned MISM_BIT_HIGH_LO   = 16;
   localparam int unsigned MISM_BIT_HIGH_HI   = 25;

   // control register fields (self clearing)
   localparam int unsigned MISM_CTL_SOFT_RST  = 0;
   localparam int unsigned MISM_CTL_SW_IRQ    = 1;
   // enable register field
   localparam int unsigned MISM_ENA_BIT       = 0;

   // AHB-Lite encodings
   localparam logic [1:0] MISM_HTRANS_NONSEQ  = 2'h2;
   localparam logic       MISM_HRESP_OKAY     = 1'h0;

   typedef enum logic [1:0] {
      MISM_BUS_IDLE  = 2'b00,
      MISM_BUS_WRITE = 2'b01,
      MISM_BUS_READ  = 2'b10
   } mism_bus_state_type;

   typedef logic [MISM_DATA_W-1:0] mism_word_type;

endpackage : mism_pkg

// >>> src/mism_evt_if.sv
/*
 * carrier between the register front end and the sticky status latch.
 * assumes both ends run on the same clock and reset.
 */
`timescale 1ns/1ps
interface mism_evt_if #(
   parameter int unsigned WIDTH = 32
);
   logic [WIDTH-1:0] set_vec;
   logic [WIDTH-1:0] clear_vec;
   logic             soft_load;
   logic [WIDTH-1:0] status_vec;

   modport ctrl  (output set_vec, output clear_vec, output soft_load, input status_vec);
   modport latch (input set_vec, input clear_vec, input soft_load, output status_vec);
endinterface : mism_evt_if

// >>> src/mism_event_latch.sv
/*
 * sticky event latch: set, clear-on-read and soft reload of the status bits.
 * assumes a synchronised active-low reset from the top module.
 */
`timescale 1ns/1ps
module mism_event_latch
   import mism_pkg::*;
#(
   parameter int unsigned   WIDTH      = 32,
   parameter logic [WIDTH-1:0] IMPL    = MISM_IMPL_BITS,
   parameter logic [WIDTH-1:0] HARD_VAL = MISM_STATUS_HARD,
   parameter logic [WIDTH-1:0] SOFT_VAL = MISM_STATUS_SOFT
) (
   // clock and reset
   input  wire logic   clk,
   input  wire logic   rst_sync_b,
   // control side
   mism_evt_if.latch   evt
);

   logic [WIDTH-1:0] status_q;
   logic [WIDTH-1:0] status_d;

   // set wins over a clear in the same cycle
   assign status_d = evt.soft_load ? (SOFT_VAL & IMPL)
                                   : ((status_q & ~evt.clear_vec) | evt.set_vec) & IMPL;

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         status_q <= HARD_VAL;
      end else begin
         status_q <= status_d;
      end
   end

   assign evt.status_vec = status_q;

endmodule : mism_event_latch

// >>> sim/mism_host.sv
/*
 * host model: ahb-lite master that performs single register accesses for the testbench.
 * assumes hready is the one slave's hreadyout and one clock.
 */
`timescale 1ns/1ps
module mism_host (
   // clock
   input  wire logic        clk,
   // ahb-lite master
   output      logic        hsel,
   output      logic [7:0]  haddr,
   output      logic [1:0]  htrans,
   output      logic        hwrite,
   output      logic [2:0]  hsize,
   output      logic [31:0] hwdata,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata
);
   import mism_pkg::*;

   initial begin
      hsel   = 1'b0;
      haddr  = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize  = 3'h2;
      hwdata = 32'h00000000;
   end

   // one single word transfer; ok stays low when the slave never answers
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic ok);
      int n;
      n = 0;
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= wr;
      htrans <= MISM_HTRANS_NONSEQ;
      do begin
         @(posedge clk);
         n++;
      end while (!hready && n < 20);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge clk);
         n++;
      end while (!hready && n < 40);
      rd = hrdata;
      ok = hready;
   endtask : xfer
endmodule : mism_host

// >>> sim/mism_top_sva.sv
/*
 * port checker of the interrupt status and mask block.
 * assumes hready is tied to hreadyout and a single clock domain.
 */
`timescale 1ns/1ps
module mism_top_sva (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_b,
   // bus
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // events and outputs
   input wire logic        rx_fifo_overrun,
   input wire logic        rx_engine_running,
   input wire logic        tx_desc_writeback,
   input wire logic        rx_desc_writeback,
   input wire logic        rx_early_threshold,
   input wire logic [31:0] aux_event,
   input wire logic        irq,
   input wire logic        soft_reset_pulse
);
   import mism_pkg::*;
   logic       run_q, ctl_q;
   logic [3:0] tr_q, cause_q;
   wire taken  = hsel && htrans == MISM_HTRANS_NONSEQ && hready;
   wire rd_tk  = taken && !hwrite;
   wire mapped = haddr inside {MISM_OFS_STATUS, MISM_OFS_MASK, MISM_OFS_ENABLE};
   wire cause  = taken || tx_desc_writeback || rx_desc_writeback || rx_fifo_overrun
                 || rx_early_threshold || (|aux_event) || (run_q && !rx_engine_running);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         run_q   <= 1'b0;
         ctl_q   <= 1'b0;
         tr_q    <= 4'h0;
         cause_q <= 4'h0;
      end else begin
         run_q   <= rx_engine_running;
         ctl_q   <= taken && hwrite && haddr == MISM_OFS_CONTROL;
         tr_q    <= {tr_q[2:0], taken};
         cause_q <= {cause_q[2:0], cause};
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   AST_HRESP_OKAY: assert property (hresp == MISM_HRESP_OKAY)
      else $error("response not okay");
   AST_READ_WAIT: assert property (rd_tk |=> !hreadyout ##1 hreadyout)
      else $error("read data phase not one wait state");
   AST_WRITE_NOWAIT: assert property (taken && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   AST_RDATA_HOLD: assert property (!$stable(hrdata) |-> $rose(hreadyout))
      else $error("read data changed outside a read completion");
   AST_UNMAPPED_ZERO: assert property (rd_tk && !mapped |-> ##2 hrdata == MISM_ZERO_WORD)
      else $error("unmapped read not zero");
   AST_RESERVED_ZERO: assert property (rd_tk && mapped |-> ##2 (hrdata & ~MISM_IMPL_BITS) == 0)
      else $error("unused bits read nonzero");
   AST_IRQ_RISE: assert property ($rose(irq) |-> |cause_q)
      else $error("interrupt rose without a cause");
   AST_IRQ_FALL: assert property ($fell(irq) |-> |tr_q)
      else $error("interrupt fell without a register access");
   AST_SRST_PULSE: assert property (ctl_q && hwdata[0] |-> ##[1:2] soft_reset_pulse)
      else $error("soft reset pulse missing");
   AST_SRST_SINGLE: assert property (soft_reset_pulse |=> !soft_reset_pulse)
      else $error("soft reset pulse longer than one cycle");
   AST_SRST_IRQ: assert property (soft_reset_pulse |-> ##2 !irq [*3])
      else $error("interrupt survives soft reset");
endmodule : mism_top_sva

bind mism_top mism_top_sva chk_u (
   .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .rx_fifo_overrun(rx_fifo_overrun), .rx_engine_running(rx_engine_running),
   .tx_desc_writeback(tx_desc_writeback), .rx_desc_writeback(rx_desc_writeback),
   .rx_early_threshold(rx_early_threshold), .aux_event(aux_event), .irq(irq),
   .soft_reset_pulse(soft_reset_pulse));

// >>> sim/tb_mac_interrupt_status_mask.sv
/*
 * self-checking testbench of the interrupt status and mask block.
 * assumes the host model and the checker are compiled before it.
 */
`timescale 1ns/1ps
module tb_mac_interrupt_status_mask;
   import mism_pkg::*;
   logic        clk, rst_b, hsel, hwrite, hreadyout, hresp, irq, srst;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, aux, rdv;
   logic [11:0] ev;
   int          n_mismatch, check_count;
   // event input patterns that set status bits 0..7 in order
   logic [11:0] code [8] = '{12'h070, 12'h090, 12'h030, 12'h200,
                             12'h800, 12'h100, 12'h007, 12'h009};

   mism_host host_u (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
                     .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
   mism_top dut_u (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp),
      .tx_desc_writeback(ev[0]), .tx_desc_last(ev[1]), .tx_status_good(ev[2]),
      .tx_descriptor_irq_request(ev[3]), .rx_desc_writeback(ev[4]), .rx_desc_last(ev[5]),
      .rx_status_good(ev[6]), .rx_descriptor_irq_request(ev[7]), .rx_fifo_overrun(ev[8]),
      .rx_early_threshold(ev[9]), .rx_packet_start(ev[10]), .rx_engine_running(ev[11]),
      .aux_event(aux), .irq(irq), .soft_reset_pulse(srst));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic close_out();
      if (n_mismatch == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      logic ok;
      host_u.xfer(wr, a, wd, rdv, ok);
      if (ok !== 1'b1) begin
         n_mismatch++;
         close_out();
      end
   endtask : bus

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(what, rdv, exp);
   endtask : rd_chk

   task automatic chk_irq(input logic exp);
      repeat (3) @(posedge clk);
      chk("irq", {31'h0, irq}, {31'h0, exp});
   endtask : chk_irq

   task automatic fire(input logic [11:0] c);
      @(posedge clk);
      ev <= c;
      @(posedge clk);
      ev <= 12'h000;
      repeat (3) @(posedge clk);
   endtask : fire

   task automatic t_events();
      rd_chk("mask", MISM_OFS_MASK, MISM_MASK_RESET);
      for (int b = 0; b < 8; b++) begin
         fire(code[b]);
         rd_chk("status", MISM_OFS_STATUS, 32'h1 << b);
         chk_irq(1'b0);
      end
      fire(12'h200);
      rd_chk("early twice", MISM_OFS_STATUS, 32'h0);
      fire(12'h400);
      fire(12'h200);
      rd_chk("early rearmed", MISM_OFS_STATUS, 32'h8);
   endtask : t_events

   task automatic t_irq();
      bus(1'b1, MISM_OFS_MASK, 32'hFFFFFFFF);
      rd_chk("mask", MISM_OFS_MASK, MISM_IMPL_BITS);
      bus(1'b1, MISM_OFS_ENABLE, 32'h1);
      fire(12'h100);
      chk_irq(1'b1);
      bus(1'b1, MISM_OFS_ENABLE, 32'h0);
      chk_irq(1'b0);
      rd_chk("mask kept", MISM_OFS_MASK, MISM_IMPL_BITS);
      bus(1'b1, MISM_OFS_ENABLE, 32'h1);
      chk_irq(1'b1);
      rd_chk("status", MISM_OFS_STATUS, 32'h20);
      chk_irq(1'b0);
      rd_chk("status cleared", MISM_OFS_STATUS, 32'h0);
   endtask : t_irq

   task automatic t_masked();
      bus(1'b1, MISM_OFS_MASK, 32'hFFFFFFDF);
      fire(12'h100);
      chk_irq(1'b0);
      fire(12'h007);
      chk_irq(1'b1);
      bus(1'b1, MISM_OFS_CONTROL, 32'h1);
      chk_irq(1'b0);
      rd_chk("mask soft", MISM_OFS_MASK, MISM_MASK_RESET);
      rd_chk("status soft", MISM_OFS_STATUS, MISM_STATUS_SOFT);
      bus(1'b1, 8'h20, 32'hFFFFFFFF);
      rd_chk("unmapped", 8'h20, 32'h0);
      rd_chk("control", MISM_OFS_CONTROL, 32'h0);
   endtask : t_masked

   // upper sources, summary bit and software interrupt; unused status positions stay clear
   task automatic t_aux();
      bus(1'b1, MISM_OFS_MASK, 32'h00200000);
      bus(1'b1, MISM_OFS_ENABLE, 32'h1);
      @(posedge clk);
      aux <= 32'hFC2E0000;
      @(posedge clk);
      aux <= 32'h0;
      chk_irq(1'b1);
      rd_chk("status high", MISM_OFS_STATUS, 32'h00208000);
      chk_irq(1'b0);
      bus(1'b1, MISM_OFS_CONTROL, 32'h2);
      chk_irq(1'b0);
      rd_chk("status swi", MISM_OFS_STATUS, 32'h00001000);
   endtask : t_aux

   // hard reset in mid-run brings mask and enable back to zero
   task automatic t_hard();
      bus(1'b1, MISM_OFS_MASK, 32'hFFFFFFFF);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      rd_chk("mask hard", MISM_OFS_MASK, MISM_MASK_RESET);
      rd_chk("enable hard", MISM_OFS_ENABLE, 32'h0);
      chk_irq(1'b0);
   endtask : t_hard

   initial begin
      rst_b = 1'b0;
      ev = 12'h000;
      aux = 32'h0;
      n_mismatch = 0;
      check_count = 0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      t_events();
      t_irq();
      t_masked();
      t_aux();
      t_hard();
      close_out();
   end
endmodule : tb_mac_interrupt_status_mask
